//--- dca_pkg.sv
// dca_pkg: constants, states and carrier structs for the direct call fsm
// assumes a single 125 MHz clock domain
package dca_pkg;
   localparam int CLK_MHZ = 125;
   localparam int DWELL_MS = 100;
   localparam int DWELL_CYC = DWELL_MS * 1000 * CLK_MHZ;
   localparam int T1_MIN_MIN = 1;
   localparam int T1_MAX_MIN = 5;
   localparam int BAUD_FAST = 1200;
   localparam int BAUD_SLOW = 300;
   localparam int BIT_CYC_FAST = CLK_MHZ * 1000000 / BAUD_FAST;
   localparam int BIT_CYC_SLOW = CLK_MHZ * 1000000 / BAUD_SLOW;
   localparam int ID_REPEAT = 3;
   localparam int FRAME_BITS = 10;
   localparam int CHAR_BITS = 7;
   localparam logic TONE_MARK = 1'b1;
   localparam logic TONE_SPACE = 1'b0;
   localparam int TW = 32;

   typedef enum logic [7:0] {
      DCA_IDLE = 8'h01,
      DCA_ATTEMPT = 8'h02,
      DCA_INCOMING = 8'h04,
      DCA_ACCEPTED = 8'h08,
      DCA_ANSWERING = 8'h10,
      DCA_DATA = 8'h20,
      DCA_IDSEND = 8'h40,
      DCA_CLEAR = 8'h80
   } dca_state_e;

   typedef enum logic [3:0] {
      DCL_DIALWAIT = 4'h1,
      DCL_DIALING = 4'h2,
      DCL_CALLTONE = 4'h4,
      DCL_CONNECT = 4'h8
   } dca_line_e;

   // terminal side interchange circuits
   typedef struct packed {
      logic connect_to_line;
      logic data_terminal_ready;
   } dca_dte_s;

   // line events coming from the analogue front end
   typedef struct packed {
      logic ring;
      logic dial_tone;
      logic dial_done;
      logic far_offhook;
      logic answer_tone;
      logic connect_done;
      logic line_lost;
   } dca_line_s;

   typedef struct packed {
      logic [TW-1:0] call_attempt_timer;
      logic [TW-1:0] post_dial_answer_timeout;
      logic [TW-1:0] post_offhook_answer_timeout;
      logic [TW-1:0] answer_timeout;
      logic [TW-1:0] dial_delay;
      logic [TW-1:0] answer_delay;
      logic [TW-1:0] dwell;
   } dca_timers_s;
endpackage

//--- dca_timer.sv
// dca_timer: reloadable down counter raising a level on expiry
// assumes load and reload are synchronous to i_clock
`timescale 1ns/100ps
module dca_timer #(
   parameter int W = 32
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_load,
   input wire logic i_run,
   input wire logic [W-1:0] i_reload,
   output logic o_expired
);
   logic [W-1:0] cnt_ff;
   logic live_ff;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cnt_ff <= '0;
         live_ff <= 1'b0;
      end else if (i_load) begin
         cnt_ff <= i_reload;
         live_ff <= 1'b1;
      end else if (!i_run) begin
         live_ff <= 1'b0;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end

   // a zero reload expires on the cycle after load
   assign o_expired = live_ff && (cnt_ff == '0);
endmodule

//--- dca_fsm.sv
// dca_fsm: direct call and answer interface machine with line procedures
// assumes all inputs synchronous to i_clock; timers reload from ports
`timescale 1ns/100ps
// Operation
// - data set ready on outgoing call established
// - retries stay in call attempt state
// - idle ring raises indicator, connect accepts
// - early incoming call dwells before answering
// - ignored ringing returns to idle
// - connect dropped while answering returns idle
// - answer completion raises data set ready
// - go off hook, dial after tone/delay
// - calling tone, answer timeout fails call
// - connecting indication before ready drops
// - identification after calling tone on timeout
// - clear deferred while identification sends
// - identification message sent three times
// - 1200 or 300 baud, mark/space tones
// - start, seven bits, even parity, stop
// - ring gives incoming indication if both on
// - answer only when connect, delay off hook
// - off hook drops ready, then data ready
// - ready for sending marks dialogue ready
// - clear in data drops data set ready
module dca_fsm #(
   parameter int ID_LEN = 8,
   parameter int IW = 4
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire dca_pkg::dca_dte_s i_dte,
   input wire dca_pkg::dca_line_s i_line,
   input wire dca_pkg::dca_timers_s i_tmr,
   input wire logic i_id_enable,
   input wire logic i_id_slow,
   input wire logic [IW-1:0] i_id_len,
   input wire logic [ID_LEN*7-1:0] i_id_chars,
   output logic o_data_set_ready,
   output logic o_calling_indicator,
   output logic o_ready_for_sending,
   output logic o_off_hook,
   output logic o_dialing,
   output logic o_calling_tone,
   output logic o_call_connecting,
   output logic o_incoming_call,
   output logic o_call_failure,
   output logic o_call_timer_expired,
   output logic o_id_active,
   output logic o_id_tone_mark,
   output logic [7:0] o_state
);
   dca_pkg::dca_state_e state_ff;
   dca_pkg::dca_line_e line_ff;
   logic ctl;
   logic [6:0] exp;
   logic dialed_ff;
   logic ring_prev_ff;
   logic id_pending_ff;
   logic id_done;
   logic [3:0] bit_ff;
   logic [IW-1:0] chr_ff;
   logic [1:0] rep_ff;
   logic [31:0] baud_ff;
   logic [9:0] frame;
   logic [6:0] cur;

   assign ctl = i_dte.connect_to_line;

   // one timer per supervised interval; loads on the entry event
   logic [6:0] ld;
   logic [6:0] run;
   logic [dca_pkg::TW-1:0] rl [7];
   assign rl[0] = i_tmr.call_attempt_timer;
   assign rl[1] = i_tmr.post_dial_answer_timeout;
   assign rl[2] = i_tmr.post_offhook_answer_timeout;
   assign rl[3] = i_tmr.answer_timeout;
   assign rl[4] = i_tmr.dial_delay;
   assign rl[5] = i_tmr.answer_delay;
   assign rl[6] = i_tmr.dwell;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_tmr
         dca_timer #(.W(dca_pkg::TW)) u_tmr (
            .i_clock(i_clock),
            .i_srst(i_srst),
            .i_load(ld[g]),
            .i_run(run[g]),
            .i_reload(rl[g]),
            .o_expired(exp[g])
         );
      end
   endgenerate

   always_comb begin
      ld = '0;
      run = '0;
      ld[0] = (state_ff == dca_pkg::DCA_IDLE) && ctl
         && !o_calling_indicator;
      run[0] = (state_ff == dca_pkg::DCA_ATTEMPT);
      ld[4] = ld[0];
      run[4] = run[0] && (line_ff == dca_pkg::DCL_DIALWAIT);
      ld[1] = run[0] && (line_ff == dca_pkg::DCL_DIALING)
         && i_line.dial_done;
      ld[2] = run[0] && (line_ff == dca_pkg::DCL_DIALING)
         && i_line.far_offhook;
      ld[3] = ld[1] || ld[2];
      run[1] = run[0] && (line_ff == dca_pkg::DCL_CALLTONE) && dialed_ff;
      run[2] = run[0] && (line_ff == dca_pkg::DCL_CALLTONE) && !dialed_ff;
      run[3] = run[0] && (line_ff == dca_pkg::DCL_CALLTONE);
      // dwell starts on either route into call accepted
      ld[6] = (run[0] && (line_ff != dca_pkg::DCL_CONNECT) && i_line.ring
         && !o_off_hook) || ((state_ff == dca_pkg::DCA_INCOMING) && ctl);
      run[6] = (state_ff == dca_pkg::DCA_ACCEPTED);
      // answer delay runs after the dwell, so the two add up
      ld[5] = run[6] && (exp[6] || !o_calling_indicator);
      run[5] = (state_ff == dca_pkg::DCA_ANSWERING);
   end

   // main interface state
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_ff <= dca_pkg::DCA_IDLE;
      end else begin
         case (state_ff)
            dca_pkg::DCA_IDLE: begin
               if (i_line.ring)
                  state_ff <= dca_pkg::DCA_INCOMING;
               else if (ctl && !o_calling_indicator)
                  state_ff <= dca_pkg::DCA_ATTEMPT;
            end
            dca_pkg::DCA_ATTEMPT: begin
               if (ld[6])
                  state_ff <= dca_pkg::DCA_ACCEPTED;
               else if (!ctl)
                  state_ff <= dca_pkg::DCA_CLEAR;
               else if (id_pending_ff)
                  state_ff <= dca_pkg::DCA_IDSEND;
               else if (line_ff == dca_pkg::DCL_CONNECT
                  && i_line.connect_done)
                  state_ff <= dca_pkg::DCA_DATA;
            end
            dca_pkg::DCA_INCOMING: begin
               if (ctl)
                  state_ff <= dca_pkg::DCA_ACCEPTED;
               else if (ring_prev_ff && !i_line.ring)
                  state_ff <= dca_pkg::DCA_IDLE;
            end
            dca_pkg::DCA_ACCEPTED: begin
               // leaves only after the dwell so the terminal sees the ring
               if (exp[6] || !o_calling_indicator)
                  state_ff <= dca_pkg::DCA_ANSWERING;
            end
            dca_pkg::DCA_ANSWERING: begin
               if (!ctl)
                  state_ff <= dca_pkg::DCA_CLEAR;
               else if (o_off_hook && i_line.connect_done)
                  state_ff <= dca_pkg::DCA_DATA;
            end
            dca_pkg::DCA_DATA: begin
               if (!ctl || i_line.line_lost)
                  state_ff <= dca_pkg::DCA_CLEAR;
            end
            dca_pkg::DCA_IDSEND: begin
               // clear requests wait until the burst is done
               if (id_done)
                  state_ff <= dca_pkg::DCA_CLEAR;
            end
            dca_pkg::DCA_CLEAR: begin
               if (!ctl)
                  state_ff <= dca_pkg::DCA_IDLE;
            end
            default: state_ff <= dca_pkg::DCA_IDLE;
         endcase
      end
   end

   // calling-side line procedure; retries re-dial within call attempt
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         line_ff <= dca_pkg::DCL_DIALWAIT;
         dialed_ff <= 1'b0;
         id_pending_ff <= 1'b0;
      end else if (state_ff != dca_pkg::DCA_ATTEMPT) begin
         line_ff <= dca_pkg::DCL_DIALWAIT;
         dialed_ff <= 1'b0;
         id_pending_ff <= 1'b0;
      end else begin
         case (line_ff)
            dca_pkg::DCL_DIALWAIT:
               if (i_line.dial_tone || exp[4])
                  line_ff <= dca_pkg::DCL_DIALING;
            dca_pkg::DCL_DIALING:
               if (i_line.dial_done || i_line.far_offhook) begin
                  line_ff <= dca_pkg::DCL_CALLTONE;
                  dialed_ff <= i_line.dial_done;
               end
            dca_pkg::DCL_CALLTONE: begin
               if (i_line.answer_tone)
                  line_ff <= dca_pkg::DCL_CONNECT;
               else if (i_id_enable && (exp[1] || exp[2]))
                  id_pending_ff <= 1'b1;
               else if (exp[3])
                  line_ff <= dca_pkg::DCL_DIALWAIT;
            end
            dca_pkg::DCL_CONNECT: line_ff <= dca_pkg::DCL_CONNECT;
            default: line_ff <= dca_pkg::DCL_DIALWAIT;
         endcase
      end
   end

   // interchange circuit and indication outputs
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_data_set_ready <= 1'b0;
         o_calling_indicator <= 1'b0;
         o_ready_for_sending <= 1'b0;
         o_off_hook <= 1'b0;
         o_dialing <= 1'b0;
         o_calling_tone <= 1'b0;
         o_call_connecting <= 1'b0;
         o_incoming_call <= 1'b0;
         o_call_failure <= 1'b0;
         o_call_timer_expired <= 1'b0;
         ring_prev_ff <= 1'b0;
      end else begin
         ring_prev_ff <= i_line.ring;
         o_data_set_ready <= (state_ff == dca_pkg::DCA_DATA) && ctl
            && !i_line.line_lost;
         if (state_ff == dca_pkg::DCA_IDLE && i_line.ring)
            o_calling_indicator <= 1'b1;
         else if (ld[6])
            o_calling_indicator <= 1'b1;
         else if (state_ff == dca_pkg::DCA_IDLE
            || state_ff == dca_pkg::DCA_CLEAR
            || state_ff == dca_pkg::DCA_DATA)
            o_calling_indicator <= 1'b0;
         o_incoming_call <= (state_ff == dca_pkg::DCA_IDLE) && i_line.ring
            && i_dte.data_terminal_ready && o_ready_for_sending;
         if (state_ff == dca_pkg::DCA_IDLE)
            o_ready_for_sending <= i_dte.data_terminal_ready;
         else if (o_call_connecting || o_off_hook)
            o_ready_for_sending <= 1'b0;
         o_call_connecting <= run[3] && i_line.answer_tone;
         o_off_hook <= (run[0] && !ld[6])
            || state_ff == dca_pkg::DCA_IDSEND
            || state_ff == dca_pkg::DCA_DATA
            || (state_ff == dca_pkg::DCA_ANSWERING && ctl && exp[5])
            || (state_ff == dca_pkg::DCA_ANSWERING && o_off_hook && ctl);
         o_dialing <= run[0] && line_ff == dca_pkg::DCL_DIALING;
         o_calling_tone <= run[3];
         o_call_failure <= run[3] && exp[3] && !i_line.answer_tone;
         o_call_timer_expired <= run[0] && exp[0]
            && !o_data_set_ready;
      end
   end

   // identification burst: 10-bit frames, whole message three times
   always_comb begin
      cur = i_id_chars[chr_ff*7 +: 7];
      frame = {1'b1, ^cur, cur, 1'b0};
   end
   assign id_done = (state_ff == dca_pkg::DCA_IDSEND)
      && rep_ff == 2'(dca_pkg::ID_REPEAT);

   always_ff @(posedge i_clock) begin
      if (i_srst || state_ff != dca_pkg::DCA_IDSEND) begin
         bit_ff <= '0;
         chr_ff <= '0;
         rep_ff <= '0;
         baud_ff <= '0;
         o_id_active <= 1'b0;
         o_id_tone_mark <= dca_pkg::TONE_MARK;
      end else if (!id_done) begin
         o_id_active <= 1'b1;
         o_id_tone_mark <= frame[bit_ff] ? dca_pkg::TONE_MARK
            : dca_pkg::TONE_SPACE;
         if (baud_ff == 32'(i_id_slow ? dca_pkg::BIT_CYC_SLOW
            : dca_pkg::BIT_CYC_FAST) - 32'd1) begin
            baud_ff <= '0;
            if (bit_ff == 4'(dca_pkg::FRAME_BITS - 1)) begin
               bit_ff <= '0;
               if (chr_ff == i_id_len - IW'(1)) begin
                  chr_ff <= '0;
                  rep_ff <= rep_ff + 2'd1;
               end else begin
                  chr_ff <= chr_ff + IW'(1);
               end
            end else begin
               bit_ff <= bit_ff + 4'd1;
            end
         end else begin
            baud_ff <= baud_ff + 32'd1;
         end
      end else begin
         o_id_active <= 1'b0;
         o_id_tone_mark <= dca_pkg::TONE_MARK;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst)
         o_state <= dca_pkg::DCA_IDLE;
      else
         o_state <= state_ff;
   end

   property p_dsr_needs_ctl;
      @(posedge i_clock) disable iff (i_srst)
      o_data_set_ready |-> $past(ctl);
   endproperty
   a_dsr_needs_ctl: assert property (p_dsr_needs_ctl)
      else $error("data set ready without connect");

   property p_abort_answer;
      @(posedge i_clock) disable iff (i_srst)
      (state_ff == dca_pkg::DCA_ANSWERING && !ctl)
         |=> state_ff == dca_pkg::DCA_CLEAR;
   endproperty
   a_abort_answer: assert property (p_abort_answer)
      else $error("answer abort not honoured");

   property p_id_defers;
      @(posedge i_clock) disable iff (i_srst)
      (state_ff == dca_pkg::DCA_IDSEND && !id_done)
         |=> state_ff == dca_pkg::DCA_IDSEND;
   endproperty
   a_id_defers: assert property (p_id_defers)
      else $error("clear acted during identification");

   property p_idle_ring;
      @(posedge i_clock) disable iff (i_srst)
      (state_ff == dca_pkg::DCA_IDLE && i_line.ring)
         |=> o_calling_indicator && state_ff == dca_pkg::DCA_INCOMING;
   endproperty
   a_idle_ring: assert property (p_idle_ring)
      else $error("ring in idle not signalled");

   property p_connecting_first;
      @(posedge i_clock) disable iff (i_srst)
      o_call_connecting |-> ##1 !o_ready_for_sending;
   endproperty
   a_connecting_first: assert property (p_connecting_first)
      else $error("ready not dropped after connecting");

   property p_offhook_rfs;
      @(posedge i_clock) disable iff (i_srst)
      $rose(o_off_hook) && state_ff == dca_pkg::DCA_ANSWERING
         |=> !o_ready_for_sending;
   endproperty
   a_offhook_rfs: assert property (p_offhook_rfs)
      else $error("ready still on after off hook");

   property p_dial_after_hook;
      @(posedge i_clock) disable iff (i_srst)
      o_dialing |-> o_off_hook;
   endproperty
   a_dial_after_hook: assert property (p_dial_after_hook)
      else $error("dialling while on hook");

   property p_ring_end;
      @(posedge i_clock) disable iff (i_srst)
      (state_ff == dca_pkg::DCA_INCOMING && !ctl && ring_prev_ff
         && !i_line.ring) |=> state_ff == dca_pkg::DCA_IDLE;
   endproperty
   a_ring_end: assert property (p_ring_end)
      else $error("ignored call did not return idle");
endmodule

//--- dca_dte_model.sv
// dca_dte_model: terminal side of the connect and ready circuits
// assumes bench commands arrive by nonblocking writes on falling edges
`timescale 1ns/100ps
module dca_dte_model (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic [1:0] i_cmd,
   input wire logic i_dtr,
   input wire logic i_abort_on_expiry,
   input wire logic i_calling_indicator,
   input wire logic i_call_timer_expired,
   input wire logic i_data_set_ready,
   output dca_pkg::dca_dte_s o_dte
);
   initial o_dte = '0;
   // commands: 1 place call, 2 accept ringing call, 3 clear
   always @(negedge i_clock) begin
      o_dte.data_terminal_ready <= i_dtr;
      if (i_srst) begin
         o_dte.connect_to_line <= 1'b0;
      end else if (i_cmd == 2'h1 && !i_calling_indicator) begin
         o_dte.connect_to_line <= 1'b1;
      end else if (i_cmd == 2'h2 && i_calling_indicator) begin
         o_dte.connect_to_line <= 1'b1;
      end else if (i_cmd == 2'h3) begin
         o_dte.connect_to_line <= 1'b0;
      end else if (i_abort_on_expiry && i_call_timer_expired &&
            !i_data_set_ready) begin
         // give up only while the call is still not through
         o_dte.connect_to_line <= 1'b0;
      end
   end
endmodule

//--- direct_call_answer_fsm_test.sv
// direct_call_answer_fsm_test: self-checking bench for dca_fsm
// assumes short timer reloads; inputs change on falling edges
`timescale 1ns/100ps
module direct_call_answer_fsm_test;
   localparam int k_ida = 0, k_tex = 1, k_fail = 2, k_con = 4, k_ctn = 5;
   localparam int k_dial = 6, k_ofh = 7, k_rfs = 8, k_ci = 9, k_dsr = 10;
   localparam int k_st = 11, k_mrk = 12, k_inc = 3;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic [1:0] cmd = 2'h0;
   logic abort_exp = 1'b0;
   logic id_en = 1'b0;
   logic id_slow = 1'b0;
   logic [3:0] id_len = 4'h1;
   logic [55:0] id_chars = '0;
   dca_pkg::dca_dte_s dte;
   dca_pkg::dca_line_s line = '0;
   dca_pkg::dca_timers_s tmr;
   logic dsr, ci, rfs, ofh, dial, ctn, con, inc, fail, tex, ida, mrk;
   logic [7:0] st;
   logic [10:0] mon;
   int fails = 0;
   int num_checks = 0;
   assign mon = {dsr, ci, rfs, ofh, dial, ctn, con, inc, fail, tex, ida};

   dca_fsm #(.ID_LEN(8), .IW(4)) dca_fsm_i (.i_clock(i_clock),
      .i_srst(i_srst), .i_dte(dte), .i_line(line), .i_tmr(tmr),
      .i_id_enable(id_en), .i_id_slow(id_slow), .i_id_len(id_len),
      .i_id_chars(id_chars), .o_data_set_ready(dsr),
      .o_calling_indicator(ci), .o_ready_for_sending(rfs),
      .o_off_hook(ofh), .o_dialing(dial), .o_calling_tone(ctn),
      .o_call_connecting(con), .o_incoming_call(inc),
      .o_call_failure(fail), .o_call_timer_expired(tex),
      .o_id_active(ida), .o_id_tone_mark(mrk), .o_state(st));

   dca_dte_model dca_dte_model_i (.i_clock(i_clock), .i_srst(i_srst),
      .i_cmd(cmd), .i_dtr(1'b1), .i_abort_on_expiry(abort_exp),
      .i_calling_indicator(ci), .i_call_timer_expired(tex),
      .i_data_set_ready(dsr), .o_dte(dte));

   initial begin
      forever #4 i_clock = ~i_clock;
   end

   function automatic logic [7:0] val(input int sel);
      if (sel == k_st) return st;
      if (sel == k_mrk) return {7'h0, mrk};
      return {7'h0, mon[sel]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // bounded wait so a stuck machine shows up as a mismatch, not a hang
   task automatic wait_v(input int sel, input logic [7:0] v, output int n);
      n = 0;
      while (val(sel) !== v && n < 3000) begin
         @(negedge i_clock);
         n++;
      end
      chk(val(sel), v);
   endtask

   task automatic issue(input logic [1:0] c);
      cmd <= c;
      @(negedge i_clock);
      cmd <= 2'h0;
   endtask

   task automatic do_reset;
      i_srst <= 1'b1;
      line <= '0;
      repeat (10) @(negedge i_clock);
      i_srst <= 1'b0;
      @(negedge i_clock);
      chk(st, 8'h01);
      chk(mon[7:0], 8'h00);
      chk({5'h0, mon[10:8]}, 8'h01);
      chk({7'h0, mrk}, 8'h01);
   endtask

   task automatic summarize;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic dial_out(output int n);
      issue(2'h1);
      wait_v(k_st, 8'h02, n);
      wait_v(k_ofh, 8'h01, n);
      line.dial_tone <= 1'b1;
      wait_v(k_dial, 8'h01, n);
      line.dial_tone <= 1'b0;
      line.dial_done <= 1'b1;
      wait_v(k_ctn, 8'h01, n);
      line.dial_done <= 1'b0;
   endtask

   initial begin
      int n;
      int adly;
      n = $urandom(32'h0000_ba0c);
      adly = 5 + $urandom % 20;
      id_slow = $urandom % 2;
      id_len = 4'(1 + $urandom % 8);
      id_chars = 56'({$urandom, $urandom});
      tmr.call_attempt_timer = 32'h0000_0258;
      // shorter than the answer timeout so identification wins the race
      tmr.post_dial_answer_timeout = 32'h0000_0064;
      tmr.post_offhook_answer_timeout = 32'h0000_00c8;
      tmr.answer_timeout = 32'h0000_0096;
      tmr.dial_delay = 32'h0000_0014;
      tmr.answer_delay = 32'(adly);
      tmr.dwell = 32'h0000_0028;
      do_reset();
      // outgoing call through to data transfer, then clear
      dial_out(n);
      line.answer_tone <= 1'b1;
      wait_v(k_con, 8'h01, n);
      wait_v(k_rfs, 8'h00, n);
      line.answer_tone <= 1'b0;
      line.connect_done <= 1'b1;
      wait_v(k_dsr, 8'h01, n);
      wait_v(k_st, 8'h20, n);
      line.connect_done <= 1'b0;
      issue(2'h3);
      wait_v(k_dsr, 8'h00, n);
      wait_v(k_st, 8'h01, n);
      // no dial tone: fixed delay, failure, retry, attempt timer abort
      abort_exp <= 1'b1;
      issue(2'h1);
      wait_v(k_st, 8'h02, n);
      wait_v(k_dial, 8'h01, n);
      chk({7'h0, n >= 18 && n <= 30}, 8'h01);
      line.dial_done <= 1'b1;
      wait_v(k_ctn, 8'h01, n);
      line.dial_done <= 1'b0;
      wait_v(k_fail, 8'h01, n);
      chk({7'h0, n >= 140 && n <= 160}, 8'h01);
      repeat (4) @(negedge i_clock);
      chk(st, 8'h02);
      wait_v(k_tex, 8'h01, n);
      wait_v(k_st, 8'h01, n);
      abort_exp <= 1'b0;
      // incoming call accepted and connected
      line.ring <= 1'b1;
      wait_v(k_inc, 8'h01, n);
      wait_v(k_ci, 8'h01, n);
      wait_v(k_st, 8'h04, n);
      issue(2'h2);
      wait_v(k_st, 8'h08, n);
      wait_v(k_st, 8'h10, n);
      chk({7'h0, n >= 38}, 8'h01);
      wait_v(k_ofh, 8'h01, n);
      chk({7'h0, n >= adly - 4 && n <= adly + 6}, 8'h01);
      line.ring <= 1'b0;
      wait_v(k_rfs, 8'h00, n);
      line.connect_done <= 1'b1;
      wait_v(k_dsr, 8'h01, n);
      wait_v(k_st, 8'h20, n);
      line.connect_done <= 1'b0;
      issue(2'h3);
      wait_v(k_st, 8'h01, n);
      // ringing left unanswered
      line.ring <= 1'b1;
      wait_v(k_ci, 8'h01, n);
      repeat (20) @(negedge i_clock);
      line.ring <= 1'b0;
      wait_v(k_st, 8'h01, n);
      wait_v(k_ci, 8'h00, n);
      // terminal aborts while answering
      line.ring <= 1'b1;
      wait_v(k_ci, 8'h01, n);
      issue(2'h2);
      wait_v(k_st, 8'h10, n);
      line.ring <= 1'b0;
      issue(2'h3);
      wait_v(k_st, 8'h01, n);
      // identification burst, clear must wait for it
      id_en <= 1'b1;
      dial_out(n);
      wait_v(k_ida, 8'h01, n);
      wait_v(k_mrk, 8'h00, n);
      issue(2'h3);
      repeat (500) @(negedge i_clock);
      chk(st, 8'h40);
      chk({7'h0, ida}, 8'h01);
      chk({7'h0, mrk}, 8'h00);
      do_reset();
      summarize();
   end

   // whole run is under 2000 cycles; this leaves ample margin
   initial begin
      repeat (60000) @(posedge i_clock);
      fails++;
      summarize();
   end
endmodule
